// File: spc_pkg.sv
`default_nettype none
package spc_pkg;

  // ********************************************************************
  // Clock and bit rates
  // ********************************************************************
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned RATE_A = 9600;
  localparam int unsigned RATE_B = 4800;
  localparam int unsigned RATE_C = 2400;
  localparam int unsigned RATE_D = 1200;
  localparam int unsigned RATE_E = 110;
  localparam int unsigned RATE_F = 150;
  localparam int unsigned RATE_G = 300;
  localparam int unsigned RATE_H = 600;
  localparam int DIV_W = 20;

  typedef logic [DIV_W-1:0] spc_div_t;
  typedef spc_div_t spc_div_tab_t [8];

  // Cycles in half a bit time at the given rate
  function automatic spc_div_t half_cycles(input int unsigned rate);
    return spc_div_t'(CLK_HZ / (2 * rate));
  endfunction

  localparam spc_div_tab_t HALF_DIV_DEFAULT = '{
    half_cycles(RATE_A), half_cycles(RATE_B), half_cycles(RATE_C), half_cycles(RATE_D),
    half_cycles(RATE_E), half_cycles(RATE_F), half_cycles(RATE_G), half_cycles(RATE_H)};

  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_SENSE = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_TXDATA = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_RXDATA = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h010;

  localparam int CTRL_TX_RATE_LSB = 0;
  localparam int CTRL_RX_RATE_LSB = 4;
  localparam int CTRL_DCE_BIT = 8;
  localparam logic [2:0] CTRL_RATE_RESET = 3'h0;
  localparam logic CTRL_DCE_RESET = 1'b0;

  // Strap positions in the sense word
  localparam int STRAP_PAR_OFF = 0;
  localparam int STRAP_EVEN = 1;
  localparam int STRAP_WL_HI = 2;
  localparam int STRAP_WL_LO = 3;
  localparam int STRAP_STOP2 = 4;
  localparam int STRAP_SPARE = 5;
  localparam int SENSE_PAR_EN_BIT = 8;
  localparam int SENSE_PAR_EVEN_BIT = 9;
  localparam int SENSE_BITS_LSB = 12;
  localparam int SENSE_STOP_LSB = 16;

  localparam int ST_TX_BUSY = 0;
  localparam int ST_RX_VALID = 1;
  localparam int ST_RX_PAR_ERR = 2;
  localparam int ST_RX_FRM_ERR = 3;
  localparam int ST_RX_OVR = 4;

  // Bit and stop lengths in half-bit ticks
  localparam logic [2:0] BIT_HALVES = 3'h2;
  localparam logic [2:0] STOP_H_1 = 3'h2;
  localparam logic [2:0] STOP_H_15 = 3'h3;
  localparam logic [2:0] STOP_H_2 = 3'h4;
  localparam logic [3:0] WL_BASE = 4'h5;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_START = 3'b001,
    S_DATA = 3'b011,
    S_PARITY = 3'b010,
    S_STOP = 3'b110
  } spc_ser_state_t;

  typedef struct packed {
    logic par_en;
    logic par_even;
    logic [3:0] bits;
    logic [2:0] stop_halves;
  } spc_frame_t;

  function automatic spc_frame_t frame_decode(input logic [5:0] s);
    spc_frame_t f;
    f.par_en = ~s[STRAP_PAR_OFF];
    f.par_even = s[STRAP_EVEN];
    f.bits = WL_BASE + {2'b00, s[STRAP_WL_LO], s[STRAP_WL_HI]};
    if (!s[STRAP_STOP2])
      f.stop_halves = STOP_H_1;
    else if (s[STRAP_WL_HI] | s[STRAP_WL_LO])
      f.stop_halves = STOP_H_2;
    else
      f.stop_halves = STOP_H_15;
    return f;
  endfunction

  function automatic logic parity_bit(input logic [7:0] d, input logic [3:0] bits,
                                      input logic even);
    logic p;
    p = 1'b0;
    for (int i = 0; i < 8; i++)
      if (i < int'(bits))
        p = p ^ d[i];
    return even ? p : ~p;
  endfunction

endpackage
`default_nettype wire

// File: spc_rate_gen.sv
`timescale 1ns/1ps
`default_nettype none
module spc_rate_gen (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire spc_pkg::spc_div_t div_i,
  output logic tick_o
);
  import spc_pkg::*;

  spc_div_t count;

  // Half-bit enable; clear restarts the period so a frame starts on a full bit
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      count <= '0;
      tick_o <= 1'b0;
    end
    else if (clear_i)
    begin
      count <= '0;
      tick_o <= 1'b0;
    end
    else if (count == spc_div_t'(div_i - 1'b1))
    begin
      count <= '0;
      tick_o <= 1'b1;
    end
    else
    begin
      count <= count + 1'b1;
      tick_o <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// File: spc_top.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Taps a,b,c give 9600, 4800, 2400
// - Taps d,e give 1200 and 110
// - Taps g,h,f give 300, 600, 150
// - Transmit and receive rates chosen independently
// - Strap high reads one, low reads zero
// - Parity off, else even or odd
// - Word length lines select 5 to 8
// - Stop select gives one or two
// - Five bits with two stops gives 1.5
// - Send and receive lines swap per role
module spc_top #(
  parameter spc_pkg::spc_div_tab_t half_div_p = spc_pkg::HALF_DIV_DEFAULT
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [spc_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [5:0] strap_i,
  input wire logic pin2_i,
  output logic pin2_o,
  output logic pin2_oe_o,
  input wire logic pin3_i,
  output logic pin3_o,
  output logic pin3_oe_o
);
  import spc_pkg::*;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    return a[ADDR_W-1:2] == ofs[ADDR_W-1:2];
  endfunction

  logic [2:0] tx_sel;
  logic [2:0] rx_sel;
  logic dce;
  logic [5:0] strap_m;
  logic [5:0] strap_s;
  logic pin2_m;
  logic pin2_s;
  logic pin3_m;
  logic pin3_s;
  spc_frame_t frame;
  spc_div_t tx_div;
  spc_div_t rx_div;
  logic tx_tick;
  logic rx_tick;
  logic acc;
  logic wr;
  logic rd_rx;
  logic tx_go;
  logic [31:0] next_prdata;
  logic next_slverr;

  spc_ser_state_t tx_state;
  logic [5:0] tx_strap;
  spc_frame_t tx_frame;
  logic [7:0] tx_data;
  logic [2:0] tx_hcnt;
  logic [3:0] tx_idx;
  logic tx_line;
  logic tx_busy;

  spc_ser_state_t rx_state;
  spc_frame_t rx_frame;
  logic rx_line;
  logic rx_clr;
  logic [7:0] rx_shift;
  logic [2:0] rx_hcnt;
  logic [3:0] rx_idx;
  logic rx_perr_pend;
  logic rx_done;
  logic [7:0] rx_data;
  logic rx_valid;
  logic rx_par_err;
  logic rx_frm_err;
  logic rx_ovr;

  // ********************************************************************
  // Pin synchronisers
  // ********************************************************************
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      strap_m <= 6'h00;
      strap_s <= 6'h00;
      pin2_m <= 1'b1;
      pin2_s <= 1'b1;
      pin3_m <= 1'b1;
      pin3_s <= 1'b1;
    end
    else
    begin
      strap_m <= strap_i;
      strap_s <= strap_m;
      pin2_m <= pin2_i;
      pin2_s <= pin2_m;
      pin3_m <= pin3_i;
      pin3_s <= pin3_m;
    end
  end

  assign frame = frame_decode(strap_s);

  // ********************************************************************
  // Rate taps
  // ********************************************************************
  assign tx_div = half_div_p[tx_sel];
  assign rx_div = half_div_p[rx_sel];

  spc_rate_gen u_tx_rate (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .clear_i(tx_go),
    .div_i(tx_div),
    .tick_o(tx_tick)
  );

  spc_rate_gen u_rx_rate (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .clear_i(rx_clr),
    .div_i(rx_div),
    .tick_o(rx_tick)
  );

  // ********************************************************************
  // APB slave
  // ********************************************************************
  assign acc = psel_i & penable_i & pready_o;
  assign wr = acc & pwrite_i;
  assign rd_rx = acc & ~pwrite_i & addr_is(paddr_i, OFS_RXDATA);
  assign tx_go = wr & addr_is(paddr_i, OFS_TXDATA) & ~tx_busy;

  always_comb
  begin
    next_prdata = 32'h0;
    next_slverr = 1'b0;
    if (addr_is(paddr_i, OFS_CTRL))
    begin
      next_prdata[CTRL_TX_RATE_LSB +: 3] = tx_sel;
      next_prdata[CTRL_RX_RATE_LSB +: 3] = rx_sel;
      next_prdata[CTRL_DCE_BIT] = dce;
    end
    else if (addr_is(paddr_i, OFS_SENSE))
    begin
      next_prdata[5:0] = strap_s;
      next_prdata[SENSE_PAR_EN_BIT] = frame.par_en;
      next_prdata[SENSE_PAR_EVEN_BIT] = frame.par_even;
      next_prdata[SENSE_BITS_LSB +: 4] = frame.bits;
      next_prdata[SENSE_STOP_LSB +: 3] = frame.stop_halves;
    end
    else if (addr_is(paddr_i, OFS_RXDATA))
      next_prdata[7:0] = rx_data;
    else if (addr_is(paddr_i, OFS_STATUS))
    begin
      next_prdata[ST_TX_BUSY] = tx_busy;
      next_prdata[ST_RX_VALID] = rx_valid;
      next_prdata[ST_RX_PAR_ERR] = rx_par_err;
      next_prdata[ST_RX_FRM_ERR] = rx_frm_err;
      next_prdata[ST_RX_OVR] = rx_ovr;
    end
    else if (!addr_is(paddr_i, OFS_TXDATA))
      next_slverr = 1'b1;
  end

  // Answer is prepared in the setup cycle, so every access has no wait state
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      prdata_o <= 32'h0;
      pslverr_o <= 1'b0;
      pready_o <= 1'b0;
    end
    else
    begin
      pready_o <= 1'b1;
      if (psel_i & ~penable_i)
      begin
        prdata_o <= next_prdata;
        pslverr_o <= next_slverr;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tx_sel <= CTRL_RATE_RESET;
      rx_sel <= CTRL_RATE_RESET;
      dce <= CTRL_DCE_RESET;
    end
    else if (wr & addr_is(paddr_i, OFS_CTRL))
    begin
      tx_sel <= pwdata_i[CTRL_TX_RATE_LSB +: 3];
      rx_sel <= pwdata_i[CTRL_RX_RATE_LSB +: 3];
      dce <= pwdata_i[CTRL_DCE_BIT];
    end
  end

  // ********************************************************************
  // Transmitter
  // ********************************************************************
  assign tx_busy = (tx_state != S_IDLE);
  assign tx_frame = frame_decode(tx_strap);

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tx_state <= S_IDLE;
      tx_strap <= 6'h00;
      tx_data <= 8'h00;
      tx_hcnt <= 3'h0;
      tx_idx <= 4'h0;
      tx_line <= 1'b1;
    end
    else
    begin
      case (tx_state)
        S_IDLE:
          if (tx_go)
          begin
            tx_strap <= strap_s;
            tx_data <= pwdata_i[7:0];
            tx_line <= 1'b0;
            tx_hcnt <= 3'h0;
            tx_state <= S_START;
          end
        S_START, S_DATA, S_PARITY:
          if (tx_tick && tx_hcnt != BIT_HALVES - 3'h1)
            tx_hcnt <= tx_hcnt + 3'h1;
          else if (tx_tick)
          begin
            tx_hcnt <= 3'h0;
            if (tx_state == S_START)
            begin
              tx_line <= tx_data[0];
              tx_idx <= 4'h1;
              tx_state <= S_DATA;
            end
            else if (tx_state == S_DATA && tx_idx != tx_frame.bits)
            begin
              tx_line <= tx_data[tx_idx[2:0]];
              tx_idx <= tx_idx + 4'h1;
            end
            else if (tx_state == S_DATA && tx_frame.par_en)
            begin
              tx_line <= parity_bit(tx_data, tx_frame.bits, tx_frame.par_even);
              tx_state <= S_PARITY;
            end
            else
            begin
              tx_line <= 1'b1;
              tx_state <= S_STOP;
            end
          end
        S_STOP:
          if (tx_tick && tx_hcnt == tx_frame.stop_halves - 3'h1)
          begin
            tx_hcnt <= 3'h0;
            tx_state <= S_IDLE;
          end
          else if (tx_tick)
            tx_hcnt <= tx_hcnt + 3'h1;
        default:
          tx_state <= S_IDLE;
      endcase
    end
  end

  // Role swap: DTE sends on pin 2, DCE on pin 3; the other pin is released
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pin2_o <= 1'b1;
      pin2_oe_o <= 1'b1;
      pin3_o <= 1'b1;
      pin3_oe_o <= 1'b0;
    end
    else
    begin
      pin2_o <= dce | tx_line;
      pin2_oe_o <= ~dce;
      pin3_o <= ~dce | tx_line;
      pin3_oe_o <= dce;
    end
  end

  // ********************************************************************
  // Receiver
  // ********************************************************************
  assign rx_line = dce ? pin2_s : pin3_s;
  assign rx_clr = (rx_state == S_IDLE) & ~rx_line;
  assign rx_done = (rx_state == S_STOP) & rx_tick & (rx_hcnt == BIT_HALVES - 3'h1);

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_state <= S_IDLE;
      rx_frame <= '0;
      rx_shift <= 8'h00;
      rx_hcnt <= 3'h0;
      rx_idx <= 4'h0;
      rx_perr_pend <= 1'b0;
    end
    else
    begin
      case (rx_state)
        S_IDLE:
          if (!rx_line)
          begin
            rx_frame <= frame;
            rx_shift <= 8'h00;
            rx_perr_pend <= 1'b0;
            rx_state <= S_START;
          end
        S_START:
          // First half tick is mid start bit; a high line there was a glitch
          if (rx_tick)
          begin
            rx_hcnt <= 3'h0;
            rx_idx <= 4'h0;
            rx_state <= rx_line ? S_IDLE : S_DATA;
          end
        S_DATA, S_PARITY, S_STOP:
          if (rx_tick && rx_hcnt != BIT_HALVES - 3'h1)
            rx_hcnt <= rx_hcnt + 3'h1;
          else if (rx_tick)
          begin
            rx_hcnt <= 3'h0;
            if (rx_state == S_DATA)
            begin
              rx_shift[rx_idx[2:0]] <= rx_line;
              rx_idx <= rx_idx + 4'h1;
              if (rx_idx == rx_frame.bits - 4'h1)
                rx_state <= rx_frame.par_en ? S_PARITY : S_STOP;
            end
            else if (rx_state == S_PARITY)
            begin
              rx_perr_pend <= rx_line != parity_bit(rx_shift, rx_frame.bits,
                                                    rx_frame.par_even);
              rx_state <= S_STOP;
            end
            else
              rx_state <= S_IDLE;
          end
        default:
          rx_state <= S_IDLE;
      endcase
    end
  end

  // Flags: a new character wins over the clearing read in the same cycle
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
      rx_par_err <= 1'b0;
      rx_frm_err <= 1'b0;
      rx_ovr <= 1'b0;
    end
    else if (rx_done)
    begin
      rx_data <= rx_shift;
      rx_valid <= 1'b1;
      rx_par_err <= rx_perr_pend;
      rx_frm_err <= ~rx_line;
      rx_ovr <= rx_ovr | (rx_valid & ~rd_rx);
    end
    else if (rd_rx)
    begin
      rx_valid <= 1'b0;
      rx_par_err <= 1'b0;
      rx_frm_err <= 1'b0;
      rx_ovr <= 1'b0;
    end
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  spc_div_t tx_gap;
  spc_div_t rx_gap;
  logic [2:0] stop_ticks;

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tx_gap <= '0;
      rx_gap <= '0;
      stop_ticks <= 3'h0;
    end
    else
    begin
      tx_gap <= tx_go ? spc_div_t'(0) : tx_tick ? spc_div_t'(1) : tx_gap + 1'b1;
      rx_gap <= rx_clr ? spc_div_t'(0) : rx_tick ? spc_div_t'(1) : rx_gap + 1'b1;
      stop_ticks <= (tx_state != S_STOP) ? 3'h0 : stop_ticks + {2'b00, tx_tick};
    end
  end

  sequence s_tx_write;
    tx_go;
  endsequence

  sequence s_start_bit;
    (tx_state == S_START && !tx_line) [*2];
  endsequence

  sequence s_stop_exit;
    tx_state == S_IDLE && $past(tx_state) == S_STOP;
  endsequence

  tx_gap_a: assert property (tx_tick && tx_busy && $stable(tx_sel) |->
                             tx_gap == tx_div)
    else $error("transmit half-bit period wrong");
  rx_gap_a: assert property (rx_tick && rx_state != S_IDLE && $stable(rx_sel) |->
                             rx_gap == rx_div)
    else $error("receive half-bit period wrong");
  sense_sync_a: assert property (##2 strap_s == $past(strap_i, 2))
    else $error("sense lines not following straps");
  parity_bit_a: assert property (tx_state == S_PARITY |-> !tx_strap[STRAP_PAR_OFF] &&
      ((tx_line ^ (^(tx_data & ((8'h01 << tx_idx) - 8'h01)))) == !tx_strap[STRAP_EVEN]))
    else $error("parity bit wrong");
  word_len_a: assert property (tx_state != S_DATA && $past(tx_state) == S_DATA |->
      tx_idx == WL_BASE + {2'b00, tx_strap[STRAP_WL_LO], tx_strap[STRAP_WL_HI]})
    else $error("word length wrong");
  stop_one_two_a: assert property (s_stop_exit |-> stop_ticks ==
      (!tx_strap[STRAP_STOP2] ? STOP_H_1 :
      (tx_strap[STRAP_WL_HI] | tx_strap[STRAP_WL_LO]) ? STOP_H_2 : STOP_H_15))
    else $error("stop length wrong");
  stop_half_a: assert property (s_stop_exit and (tx_strap[STRAP_STOP2] &&
      !tx_strap[STRAP_WL_HI] && !tx_strap[STRAP_WL_LO]) |-> stop_ticks == 3'h3)
    else $error("one and a half stop bits wrong");
  role_swap_a: assert property (dce |=> pin3_oe_o && !pin2_oe_o &&
                                pin3_o == $past(tx_line))
    else $error("DCE role does not send on pin 3");
  role_dte_a: assert property (!dce |=> pin2_oe_o && !pin3_oe_o &&
                               pin2_o == $past(tx_line))
    else $error("DTE role does not send on pin 2");
  tx_start_a: assert property (s_tx_write |=> s_start_bit)
    else $error("start bit missing after transmit write");

endmodule
`default_nettype wire

// File: spc_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module spc_far_model (
  input wire logic core_clk_i,
  input wire logic dce_i,
  input wire logic [3:0] bits_i,
  input wire logic par_en_i,
  input wire logic par_even_i,
  input wire logic [19:0] half_i,
  input wire logic pin2_i,
  input wire logic pin3_i,
  output logic pin2_o,
  output logic pin2_oe_o,
  output logic pin3_o,
  output logic pin3_oe_o,
  output logic [7:0] got_o,
  output logic got_ok_o,
  output logic [15:0] got_cnt_o
);
  import spc_pkg::*;
  logic line;
  logic rx_line;
  logic [7:0] rd;
  logic rp;
  logic ok;

  initial line = 1'b1;
  initial got_cnt_o = '0;
  assign pin2_o = line;
  assign pin3_o = line;
  // A modem-role partner sends on pin3, a terminal-role partner on pin2
  assign pin2_oe_o = ~dce_i;
  assign pin3_oe_o = dce_i;
  assign rx_line = dce_i ? pin2_i : pin3_i;

  // ********************************************************************
  // Sender
  // ********************************************************************
  task automatic send(input logic [7:0] d, input logic [2:0] stop_h, input logic bad_par,
                      input logic [19:0] h);
    logic p;
    p = ~par_even_i;
    @(posedge core_clk_i);
    line <= 1'b0;
    repeat (2 * h) @(posedge core_clk_i);
    for (int i = 0; i < int'(bits_i); i++)
    begin
      line <= d[i];
      p = p ^ d[i];
      repeat (2 * h) @(posedge core_clk_i);
    end
    if (par_en_i)
    begin
      // Corrupted parity only when a scenario asks for it
      line <= p ^ bad_par;
      repeat (2 * h) @(posedge core_clk_i);
    end
    line <= 1'b1;
    repeat (int'(stop_h) * h) @(posedge core_clk_i);
  endtask

  // ********************************************************************
  // Receiver, sampling at mid bit
  // ********************************************************************
  always
  begin
    @(negedge rx_line);
    repeat (half_i) @(posedge core_clk_i);
    rd = '0;
    rp = ~par_even_i;
    ok = ~rx_line;
    for (int i = 0; i < int'(bits_i); i++)
    begin
      repeat (2 * half_i) @(posedge core_clk_i);
      rd[i] = rx_line;
      rp = rp ^ rx_line;
    end
    if (par_en_i)
    begin
      repeat (2 * half_i) @(posedge core_clk_i);
      ok = ok & (rx_line == rp);
    end
    repeat (2 * half_i) @(posedge core_clk_i);
    ok = ok & rx_line;
    got_o <= rd;
    got_ok_o <= ok;
    got_cnt_o <= got_cnt_o + 16'h1;
  end
endmodule
`default_nettype wire

// File: tb_serial_port_config_select.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) \
  begin n_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("mismatch at %0t: %s", $time, m); end end
module tb_serial_port_config_select;
  import spc_pkg::*;
  localparam int unsigned RATES [8] = '{9600, 4800, 2400, 1200,
    110, 150, 300, 600};
  logic clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [5:0] strap;
  logic d2o, d2oe, d3o, d3oe, f2o, f2oe, f3o, f3oe, pin2_w, pin3_w;
  logic far_dce, far_par, far_even, got_ok;
  logic [3:0] far_bits;
  logic [19:0] far_h;
  logic [7:0] got;
  logic [15:0] got_cnt;
  int n_errors, n_checks, cyc;
  integer seed;

  // ********************************************************************
  // Expectations
  // ********************************************************************
  // Taps scaled down by 1302 so the slowest frame stays short
  function automatic spc_div_tab_t mk_tab();
    spc_div_tab_t t;
    for (int i = 0; i < 8; i++)
      t[i] = spc_div_t'(CLK_HZ / (2 * RATES[i]) / 1302);
    return t;
  endfunction
  localparam spc_div_tab_t TAB = mk_tab();
  function automatic int nbits(input logic [5:0] s);
    return 5 + 2 * s[3] + s[2];
  endfunction
  function automatic logic [2:0] stop_h(input logic [5:0] s);
    return !s[4] ? 3'h2 : ((s[3] | s[2]) ? 3'h4 : 3'h3);
  endfunction
  function automatic logic [31:0] sense_exp(input logic [5:0] s);
    return {13'h0, stop_h(s), 4'(nbits(s)), 2'h0, s[1], ~s[0], 2'h0, s};
  endfunction
  function automatic int frame_len(input logic [5:0] s, input int h);
    return 2 * h * (1 + nbits(s) + (s[0] ? 0 : 1)) + h * int'(stop_h(s));
  endfunction

  // Released lines rest at mark
  assign pin2_w = d2oe ? d2o : (f2oe ? f2o : 1'b1);
  assign pin3_w = d3oe ? d3o : (f3oe ? f3o : 1'b1);

  spc_top #(.half_div_p(TAB)) dut (.core_clk_i(clk), .rst_i(rst), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .strap_i(strap),
    .pin2_i(pin2_w), .pin2_o(d2o), .pin2_oe_o(d2oe), .pin3_i(pin3_w), .pin3_o(d3o),
    .pin3_oe_o(d3oe));
  spc_far_model far (.core_clk_i(clk), .dce_i(far_dce), .bits_i(far_bits), .par_en_i(far_par),
    .par_even_i(far_even), .half_i(far_h), .pin2_i(pin2_w), .pin3_i(pin3_w), .pin2_o(f2o),
    .pin2_oe_o(f2oe), .pin3_o(f3o), .pin3_oe_o(f3oe), .got_o(got), .got_ok_o(got_ok),
    .got_cnt_o(got_cnt));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  // ********************************************************************
  // Bus and closing tasks
  // ********************************************************************
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial
  begin
    logic [31:0] rd;
    logic err;
    logic [5:0] s;
    logic [7:0] d, m;
    int t0, k;
    seed = 32'h6c04;
    {psel, penable, pwrite, paddr, pwdata, strap} = '0;
    rst = 1'b1;
    {far_dce, far_par, far_even, far_bits, far_h} = {3'b100, 4'h8, 20'h4};
    repeat (10) @(posedge clk);
    `CHK({d2o, d2oe, d3o, d3oe}, 4'b1110, "reset pins")
    rst <= 1'b0;
    apb(1'b0, OFS_CTRL, 32'h0, rd, err);
    `CHK(rd[8:0], 9'h0, "ctrl reset")
    apb(1'b0, 12'h014, 32'h0, rd, err);
    `CHK(err, 1'b1, "unmapped")
    for (int i = 0; i < 64; i++)
    begin
      strap <= 6'(i);
      repeat (4) @(posedge clk);
      apb(1'b0, OFS_SENSE, 32'h0, rd, err);
      `CHK(rd, sense_exp(6'(i)), "sense word")
    end
    for (int i = 0; i < 8; i++)
    begin
      // One tap per direction, roles alternate
      apb(1'b1, OFS_CTRL, {23'h0, i[0], 1'b0, 3'(7 - i), 1'b0, 3'(i)}, rd, err);
      s = 6'($random(seed));
      if (i == 4)
        s[0] = 1'b0;
      strap <= s;
      far_dce <= ~i[0];
      far_bits <= 4'(nbits(s));
      far_par <= ~s[0];
      far_even <= s[1];
      far_h <= TAB[i];
      repeat (4) @(posedge clk);
      `CHK({d2oe, d3oe}, {~i[0], i[0]}, "pin roles")
      d = 8'($random(seed));
      m = 8'hff >> (8 - nbits(s));
      k = int'(got_cnt);
      apb(1'b1, OFS_TXDATA, {24'h0, d}, rd, err);
      t0 = cyc;
      rd = 32'h1;
      for (int j = 0; j < 50000 && rd[0] !== 1'b0; j++)
        apb(1'b0, OFS_STATUS, 32'h0, rd, err);
      `CHK(rd[0], 1'b0, "tx busy stuck")
      k = k + 1;
      `CHK(got_cnt, 16'(k), "tx count")
      `CHK({got & m, got_ok}, {d & m, 1'b1}, "tx char")
      k = frame_len(s, int'(TAB[i]));
      `CHK(cyc - t0 > k && cyc - t0 <= k + 6, 1'b1, "tx frame length")
      d = 8'($random(seed));
      far.send(d, stop_h(s), i == 4, TAB[7 - i]);
      apb(1'b0, OFS_STATUS, 32'h0, rd, err);
      `CHK(rd[4:1], {2'b00, 1'(i == 4), 1'b1}, "rx status")
      apb(1'b0, OFS_RXDATA, 32'h0, rd, err);
      `CHK(rd[7:0], d & m, "rx char")
    end
    // Second character before the first is read sets overrun
    far.send(8'h3c, stop_h(s), 1'b0, TAB[0]);
    far.send(8'hc3, stop_h(s), 1'b0, TAB[0]);
    apb(1'b0, OFS_STATUS, 32'h0, rd, err);
    `CHK(rd[4:1], 4'b1001, "rx overrun")
    apb(1'b0, OFS_RXDATA, 32'h0, rd, err);
    `CHK(rd[7:0], 8'hc3 & m, "rx last char")
    apb(1'b0, OFS_STATUS, 32'h0, rd, err);
    `CHK(rd[4:1], 4'h0, "rx flags cleared by read")
    stop_test();
  end

  initial
  begin
    // Longest run is about 45000 cycles
    repeat (90000) @(posedge clk);
    n_errors++;
    $display("mismatch at %0t: watchdog", $time);
    stop_test();
  end
endmodule
`default_nettype wire
